/* hw/nib_host.sv */
`timescale 1ns/1ps
module nib_host #(
  parameter int RBV_CYC  = nib_pkg::RBV_CYC_DEF,
  parameter int PWR_CYC  = nib_pkg::PWR_CYC_DEF,
  parameter int BUSY_CYC = nib_pkg::RST_CYC_DEF
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Configuration
  input  wire logic              rb_monitor,
  // Request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  nib_pkg::nib_op_t       req_op,
  input  wire logic [23:0]       req_addr,
  input  wire logic [31:0]       req_wdata,
  input  wire logic [7:0]        req_nread,
  // Answer
  output logic                   rd_valid,
  output logic [7:0]             rd_data,
  output logic                   done,
  output logic                   err,
  output logic                   init_done,
  output logic                   nand_ready,
  // Flash pins
  output logic                   ce_n,
  output logic                   cle,
  output logic                   ale,
  output logic                   we_n,
  output logic                   read_strobe_n,
  output logic [7:0]             io_out,
  output logic                   io_oe_n,
  input  wire logic [7:0]        io_in,
  input  wire logic              rdy_busy_n
);
  import nib_pkg::*;

  typedef enum logic [8:0] {
    S_PWR  = 9'h001,
    S_IDLE = 9'h002,
    S_CMD1 = 9'h004,
    S_ADDR = 9'h008,
    S_DIN  = 9'h010,
    S_CMD2 = 9'h020,
    S_WAIT = 9'h040,
    S_READ = 9'h080,
    S_DONE = 9'h100
  } nib_st_t;

  localparam logic [CNT_W-1:0] RBV_LAST  = CNT_W'(RBV_CYC - 1);
  localparam logic [CNT_W-1:0] PWR_LAST  = CNT_W'(PWR_CYC - 1);
  localparam logic [CNT_W-1:0] BUSY_LAST = CNT_W'(BUSY_CYC - 1);
  localparam logic [CNT_W-1:0] WB_SEEN   = CNT_W'(WB_CYC + SYNC_LAT);

  nib_st_t      state;
  nib_st_t      after_addr;
  nib_st_t      after_din;
  nib_st_t      after_cmd2;
  nib_st_t      after_wait;
  nib_opinfo_t  inf;
  nib_opinfo_t  req_inf;
  logic [CNT_W-1:0] cnt;
  logic [7:0]   idx;
  logic [23:0]  addr;
  logic [31:0]  wdata;
  logic [7:0]   nread;
  logic         pend;
  logic         issuing;
  logic         wait_done;
  logic [2:0]   rb_s;
  logic         rb_hi;

  nib_cyc_if cyc ();

  nib_bus_cycle u_bus (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .cyc           (cyc.phy),
    .cle           (cle),
    .ale           (ale),
    .we_n          (we_n),
    .read_strobe_n (read_strobe_n),
    .io_out        (io_out),
    .io_oe_n       (io_oe_n),
    .io_in         (io_in)
  );

  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] i);
    return w[8*i +: 8];
  endfunction

  // Shared open-drain line: high only when every die of every target is ready
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rb_s  <= 3'h0;
      rb_hi <= 1'b0;
    end else begin
      rb_s <= {rb_s[1:0], rdy_busy_n};
      if (rb_s[1] == rb_s[2]) begin
        rb_hi <= rb_s[2];
      end
    end
  end

  assign nand_ready = rb_hi;
  assign req_inf    = nib_op_decode(req_op);
  assign req_ready  = (state == S_IDLE);
  assign after_wait = (inf.reads && nread != 8'h00) ? S_READ : S_DONE;
  assign after_cmd2 = inf.wait_busy ? S_WAIT : after_wait;
  assign after_din  = inf.cmd2_en ? S_CMD2 : after_cmd2;
  assign after_addr = (inf.ndin != 3'h0) ? S_DIN : after_din;
  assign issuing    = (state == S_CMD1) || (state == S_ADDR) || (state == S_DIN) ||
                      (state == S_CMD2) || (state == S_READ);
  // Line seen high after the busy edge could show, or the counter ran out
  assign wait_done  = (cnt == BUSY_LAST) ||
                      (rb_monitor && cnt >= WB_SEEN && rb_hi);

  always_comb begin
    cyc.start = issuing && !pend;
    cyc.kind  = CY_CMD;
    cyc.wbyte = inf.cmd1;
    case (state)
      S_ADDR: begin
        cyc.kind  = CY_ADDR;
        cyc.wbyte = pick({8'h00, addr}, idx[1:0]);
      end
      S_DIN: begin
        cyc.kind  = CY_DIN;
        cyc.wbyte = pick(wdata, idx[1:0]);
      end
      S_CMD2:  cyc.wbyte = inf.cmd2;
      S_READ:  cyc.kind = CY_DOUT;
      default: cyc.kind = CY_CMD;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (cyc.done) begin
      pend <= 1'b0;
    end else if (cyc.start) begin
      pend <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state     <= S_PWR;
      cnt       <= '0;
      idx       <= 8'h00;
      inf       <= '0;
      addr      <= 24'h00_0000;
      wdata     <= 32'h0000_0000;
      nread     <= 8'h00;
      ce_n      <= 1'b1;
      init_done <= 1'b0;
    end else begin
      case (state)
        S_PWR: begin
          // Line valid first, then high or the blind wait elapsed
          if (cnt >= RBV_LAST && (rb_monitor ? rb_hi : cnt >= PWR_LAST)) begin
            inf   <= nib_op_decode(OP_RESET);
            ce_n  <= 1'b0;
            cnt   <= '0;
            state <= S_CMD1;
          end else if (cnt != '1) begin
            cnt <= cnt + 1'b1;
          end
        end
        S_IDLE: begin
          cnt <= '0;
          idx <= 8'h00;
          // Only status reads and reset go out while the line shows busy
          if (req_valid && (req_inf.busy_ok || rb_hi)) begin
            inf   <= req_inf;
            addr  <= req_addr;
            wdata <= req_wdata;
            nread <= req_nread;
            ce_n  <= 1'b0;
            state <= S_CMD1;
          end
        end
        S_CMD1: if (cyc.done) begin
          state <= (inf.naddr != 2'h0) ? S_ADDR : after_addr;
        end
        S_ADDR: if (cyc.done) begin
          if (idx == 8'(inf.naddr) - 8'h01) begin
            idx   <= 8'h00;
            state <= after_addr;
          end else begin
            idx <= idx + 8'h01;
          end
        end
        S_DIN: if (cyc.done) begin
          if (idx == 8'(inf.ndin) - 8'h01) begin
            idx   <= 8'h00;
            state <= after_din;
          end else begin
            idx <= idx + 8'h01;
          end
        end
        S_CMD2: if (cyc.done) begin
          state <= after_cmd2;
        end
        S_WAIT: begin
          if (wait_done) begin
            cnt   <= '0;
            state <= after_wait;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        S_READ: if (cyc.done) begin
          if (idx == nread - 8'h01) begin
            state <= S_DONE;
          end else begin
            idx <= idx + 8'h01;
          end
        end
        S_DONE: begin
          ce_n      <= 1'b1;
          init_done <= 1'b1;
          state     <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      done     <= 1'b0;
      err      <= 1'b0;
    end else begin
      rd_valid <= (state == S_READ) && cyc.done;
      if ((state == S_READ) && cyc.done) begin
        rd_data <= cyc.rbyte;
      end
      done <= (state == S_DONE);
      err  <= (state == S_IDLE) && req_valid && !req_inf.busy_ok && !rb_hi;
    end
  end

  AST_PWR_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == S_PWR) |-> (we_n && read_strobe_n && ce_n))
    else $error("Bus active during power-up wait");

  AST_PWR_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == S_CMD1 && $past(state) == S_PWR) |-> ($past(cnt) >= RBV_LAST))
    else $error("Power-up wait ended early");

  AST_FIRST_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
    (cyc.start && !init_done) |-> (cyc.kind == CY_CMD && cyc.wbyte == CMD_RESET))
    else $error("First command is not reset");

  AST_REFUSE_BUSY: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == S_IDLE && req_valid && !rb_hi && !req_inf.busy_ok) |=> (err && state == S_IDLE))
    else $error("Busy-invalid command not refused");

  AST_WAIT_BOUND: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == S_WAIT) |-> (cnt <= BUSY_LAST))
    else $error("Busy wait overran its limit");

  AST_WAIT_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == S_WAIT) |-> (we_n && read_strobe_n && !ce_n))
    else $error("Strobe during busy wait");

  AST_BLIND_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(state) == S_WAIT && state != S_WAIT && !$past(rb_monitor))
      |-> ($past(cnt) == BUSY_LAST))
    else $error("Unmonitored busy wait ended early");

  AST_SETF_BYTES: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == S_DIN && $past(state) == S_ADDR) |-> (inf.ndin == 3'h4 && inf.cmd1 == CMD_SETF))
    else $error("Data input outside set features");

endmodule

/* hw/nib_pkg.sv */
package nib_pkg;

  // Host clock
  localparam int CLK_NS = 10;

  // Strobe shaping, in ns
  localparam int T_WP_NS  = 20;
  localparam int T_WH_NS  = 20;
  localparam int T_RP_NS  = 80;
  localparam int T_REH_NS = 20;
  localparam int T_WB_NS  = 100;

  // Power-up and reset waits
  localparam int T_RBV_US = 50;
  localparam int T_PWR_US = 100;
  localparam int T_RST_MS = 1;

  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WP_CYC      = ns2cyc(T_WP_NS);
  localparam int WH_CYC      = ns2cyc(T_WH_NS);
  localparam int RP_CYC      = ns2cyc(T_RP_NS);
  localparam int REH_CYC     = ns2cyc(T_REH_NS);
  localparam int WB_CYC      = ns2cyc(T_WB_NS);
  localparam int SYNC_LAT    = 3;
  localparam int RBV_CYC_DEF = (T_RBV_US * 1000) / CLK_NS;
  localparam int PWR_CYC_DEF = (T_PWR_US * 1000) / CLK_NS;
  localparam int RST_CYC_DEF = (T_RST_MS * 1000000) / CLK_NS;
  localparam int CNT_W       = 20;

  // Command codes
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  localparam logic [7:0] CMD_READ_ID   = 8'h90;
  localparam logic [7:0] CMD_PARAM     = 8'hEC;
  localparam logic [7:0] CMD_UID       = 8'hED;
  localparam logic [7:0] CMD_GETF      = 8'hEE;
  localparam logic [7:0] CMD_SETF      = 8'hEF;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_STAT_ENH  = 8'h78;
  localparam logic [7:0] CMD_RAND_RD   = 8'h05;
  localparam logic [7:0] CMD_RAND_CONF = 8'hE0;

  typedef enum logic [3:0] {
    OP_RESET     = 4'h0,
    OP_READ_ID   = 4'h1,
    OP_PARAM     = 4'h2,
    OP_UID       = 4'h3,
    OP_GETF      = 4'h4,
    OP_SETF      = 4'h5,
    OP_STATUS    = 4'h6,
    OP_STAT_ENH  = 4'h7,
    OP_RAND_READ = 4'h8
  } nib_op_t;

  typedef enum logic [1:0] {
    CY_CMD  = 2'h0,
    CY_ADDR = 2'h1,
    CY_DIN  = 2'h2,
    CY_DOUT = 2'h3
  } nib_cyc_t;

  typedef struct packed {
    logic [7:0] cmd1;
    logic [1:0] naddr;
    logic [2:0] ndin;
    logic       cmd2_en;
    logic [7:0] cmd2;
    logic       wait_busy;
    logic       reads;
    logic       busy_ok;
  } nib_opinfo_t;

  // Cycle layout of each command sequence
  function automatic nib_opinfo_t nib_op_decode(input nib_op_t op);
    nib_opinfo_t r;
    r = '0;
    case (op)
      OP_RESET:     begin r.cmd1 = CMD_RESET; r.wait_busy = 1'b1; r.busy_ok = 1'b1; end
      OP_READ_ID:   begin r.cmd1 = CMD_READ_ID; r.naddr = 2'h1; r.reads = 1'b1; end
      OP_PARAM:     begin
        r.cmd1 = CMD_PARAM; r.naddr = 2'h1; r.wait_busy = 1'b1; r.reads = 1'b1;
      end
      OP_UID:       begin r.cmd1 = CMD_UID; r.naddr = 2'h1; r.reads = 1'b1; end
      OP_GETF:      begin
        r.cmd1 = CMD_GETF; r.naddr = 2'h1; r.wait_busy = 1'b1; r.reads = 1'b1;
      end
      OP_SETF:      begin
        r.cmd1 = CMD_SETF; r.naddr = 2'h1; r.ndin = 3'h4; r.wait_busy = 1'b1;
      end
      OP_STATUS:    begin r.cmd1 = CMD_STATUS; r.reads = 1'b1; r.busy_ok = 1'b1; end
      OP_STAT_ENH:  begin
        r.cmd1 = CMD_STAT_ENH; r.naddr = 2'h3; r.reads = 1'b1; r.busy_ok = 1'b1;
      end
      OP_RAND_READ: begin
        r.cmd1 = CMD_RAND_RD; r.naddr = 2'h2; r.cmd2_en = 1'b1; r.cmd2 = CMD_RAND_CONF;
        r.reads = 1'b1;
      end
      default:      r.cmd1 = CMD_STATUS;
    endcase
    return r;
  endfunction

endpackage

/* hw/nib_cyc_if.sv */
`timescale 1ns/1ps
interface nib_cyc_if;
  logic                 start;
  nib_pkg::nib_cyc_t    kind;
  logic [7:0]           wbyte;
  logic                 done;
  logic [7:0]           rbyte;

  modport seq (output start, kind, wbyte, input done, rbyte);
  modport phy (input start, kind, wbyte, output done, rbyte);
endinterface

/* hw/nib_bus_cycle.sv */
`timescale 1ns/1ps
module nib_bus_cycle (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Sequencer side
  nib_cyc_if.phy           cyc,
  // Flash bus
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             read_strobe_n,
  output logic [7:0]       io_out,
  output logic             io_oe_n,
  input  wire logic [7:0]  io_in
);
  import nib_pkg::*;

  typedef enum logic [3:0] {
    B_IDLE = 4'h1,
    B_SET  = 4'h2,
    B_LOW  = 4'h4,
    B_HIGH = 4'h8
  } nib_bst_t;

  localparam logic [3:0] WP_L  = 4'(WP_CYC - 1);
  localparam logic [3:0] WH_L  = 4'(WH_CYC - 1);
  localparam logic [3:0] RP_L  = 4'(RP_CYC - 1);
  localparam logic [3:0] REH_L = 4'(REH_CYC - 1);

  nib_bst_t    bst;
  nib_cyc_t    kd;
  logic [3:0]  cnt;
  logic [3:0]  low_last;
  logic [3:0]  high_last;
  logic [7:0]  io_s1;
  logic [7:0]  io_s2;
  logic [7:0]  io_s3;

  assign low_last  = (kd == CY_DOUT) ? RP_L : WP_L;
  assign high_last = (kd == CY_DOUT) ? REH_L : WH_L;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      io_s3 <= 8'h00;
    end else begin
      io_s1 <= io_in;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bst           <= B_IDLE;
      kd            <= CY_CMD;
      cnt           <= 4'h0;
      cle           <= 1'b0;
      ale           <= 1'b0;
      we_n          <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out        <= 8'h00;
      io_oe_n       <= 1'b1;
      cyc.done      <= 1'b0;
      cyc.rbyte     <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      case (bst)
        B_IDLE: if (cyc.start) begin
          // Byte on io[7:0]; command latch high for commands, address latch high for addresses
          kd      <= cyc.kind;
          cle     <= (cyc.kind == CY_CMD);
          ale     <= (cyc.kind == CY_ADDR);
          io_out  <= cyc.wbyte;
          io_oe_n <= (cyc.kind == CY_DOUT);
          bst     <= B_SET;
        end
        B_SET: begin
          cnt <= 4'h0;
          bst <= B_LOW;
          if (kd == CY_DOUT) begin
            read_strobe_n <= 1'b0;
          end else begin
            we_n <= 1'b0;
          end
        end
        B_LOW: begin
          // A read byte counts only once the last two sync stages agree
          if (cnt >= low_last && (kd != CY_DOUT || io_s2 == io_s3)) begin
            cnt           <= 4'h0;
            we_n          <= 1'b1;
            read_strobe_n <= 1'b1;
            bst           <= B_HIGH;
            if (kd == CY_DOUT) begin
              cyc.rbyte <= io_s3;
            end
          end else if (cnt < low_last) begin
            cnt <= cnt + 4'h1;
          end
        end
        B_HIGH: begin
          if (cnt == high_last) begin
            cyc.done <= 1'b1;
            cle      <= 1'b0;
            ale      <= 1'b0;
            io_oe_n  <= 1'b1;
            bst      <= B_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        default: bst <= B_IDLE;
      endcase
    end
  end

  AST_WE_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(we_n) |-> !we_n [*2] ##1 we_n)
    else $error("Write strobe low time wrong");

  AST_CMD_LEVELS: assert property (@(posedge mclk) disable iff (!rst_n)
    (cle && !we_n) |-> (!ale && read_strobe_n && !io_oe_n))
    else $error("Command latch with bad control levels");

  AST_NO_DRIVE_ON_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    !read_strobe_n |-> (io_oe_n && we_n && !cle && !ale))
    else $error("Host drives bus during read");

endmodule

/* tb/nib_flash_model.sv */
`timescale 1ns/1ps
module nib_flash_model
  import nib_pkg::*;
#(
  parameter int PWR_NS  = 600,
  parameter int BUSY_NS = 1000
) (
  // Flash pins
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] bus,
  output logic [7:0]      dq,
  output logic            dq_oe_n,
  output logic            rb_oe_n,
  // Scenario hook
  input  wire logic       die1_hold
);
  logic       pwr_busy = 1'b1;
  logic       rst_busy = 1'b0;
  logic [1:0] busy;
  logic       sel;
  logic [7:0] cmd1      = 8'h00;
  logic [7:0] cmd2      = 8'h00;
  logic [7:0] first_cmd = 8'h00;
  logic [7:0] abuf [4];
  logic [7:0] dbuf [4];
  int         n_addr    = 0;
  int         n_din     = 0;
  int         n_cmd     = 0;
  int         n_rd      = 0;
  int         n_rst     = 0;
  time        first_t   = 0;

  // Target busy while any die busy; open drain pulls low only then
  assign busy    = {die1_hold | rst_busy, pwr_busy | rst_busy};
  assign rb_oe_n = ~|busy;

  // Comes up in the asynchronous mode with no setup
  initial begin
    dq = 8'h5a;
    dq_oe_n = 1'b1;
    #(PWR_NS);
    pwr_busy = 1'b0;
  end

  always @(n_rst) begin
    rst_busy = 1'b1;
    #(BUSY_NS);
    rst_busy = 1'b0;
  end

  always @(posedge we_n) begin
    if (!ce_n && read_strobe_n) begin
      if (cle && !ale) begin
        if (n_cmd == 0) begin
          first_cmd = bus;
          first_t = $time;
        end
        n_cmd++;
        if (bus == CMD_RESET) n_rst++;
        if (bus == CMD_RAND_CONF) cmd2 = bus;
        else if (!busy[0] || bus inside {CMD_STATUS, CMD_STAT_ENH, CMD_RESET}) begin
          cmd1 = bus;
          cmd2 = 8'h00;
          n_addr = 0;
          n_din = 0;
          n_rd = 0;
        end
      end else if (ale && !cle) begin
        if (n_addr < 4) abuf[n_addr] = bus;
        n_addr++;
      end else if (!ale && !cle) begin
        if (n_din < 4) dbuf[n_din] = bus;
        n_din++;
      end
    end
  end

  always @(negedge read_strobe_n) begin
    if (!ce_n && !cle && !ale) begin
      sel = (cmd1 == CMD_STAT_ENH) ? abuf[2][0] : 1'b0;
      if (cmd1 == CMD_STATUS || cmd1 == CMD_STAT_ENH) dq = {1'b0, !busy[sel], 6'h00};
      else dq = cmd1 ^ n_rd[7:0];
      dq_oe_n = 1'b0;
    end
  end

  // Released bus shows the inverse so a stale byte never looks valid
  always @(posedge read_strobe_n) begin
    if (!dq_oe_n) begin
      n_rd++;
      #5;
      dq_oe_n = 1'b1;
      dq = ~dq;
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import nib_pkg::*;
  localparam int BUSY = 200;
  logic       mclk       = 1'b0;
  logic       rst_n      = 1'b0;
  logic       rb_monitor = 1'b1;
  logic       req_valid  = 1'b0;
  nib_op_t    req_op     = OP_STATUS;
  logic [23:0] req_addr  = 24'h00_0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic [7:0] req_nread  = 8'h00;
  logic       die1_hold  = 1'b0;
  logic       req_ready, rd_valid, done, err, init_done, nand_ready;
  logic       ce_n, cle, ale, we_n, read_strobe_n, io_oe_n, dq_oe_n, rb_oe_n;
  logic [7:0] rd_data, io_out, io_in, dq;
  logic       rdy_busy_n;
  logic [8:0] exp_q [$];
  logic [7:0] codes [9] = '{CMD_RESET, CMD_READ_ID, CMD_PARAM, CMD_UID, CMD_GETF,
                            CMD_SETF, CMD_STATUS, CMD_STAT_ENH, CMD_RAND_RD};
  int         naddr [9] = '{0, 1, 1, 1, 1, 1, 0, 3, 2};
  int         n_fail    = 0;
  int         compares  = 0;
  int         cyc       = 0;
  int         seed;

  // Pull-up on ready/busy: high unless the device pulls it low
  assign rdy_busy_n = rb_oe_n;
  assign io_in      = io_oe_n ? dq : io_out;

  always #5 mclk = ~mclk;

  nib_host #(.RBV_CYC(20), .PWR_CYC(40), .BUSY_CYC(BUSY)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .rb_monitor(rb_monitor), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_nread(req_nread), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .err(err),
    .init_done(init_done), .nand_ready(nand_ready), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe_n(io_oe_n),
    .io_in(io_in), .rdy_busy_n(rdy_busy_n));

  nib_flash_model i_flash (
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
    .bus(io_in), .dq(dq), .dq_oe_n(dq_oe_n), .rb_oe_n(rb_oe_n), .die1_hold(die1_hold));

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    compares++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Results are matched against the oldest expectation
  always @(negedge mclk) begin
    if (rd_valid === 1'b1 || err === 1'b1) begin
      if (exp_q.size() == 0) check(32'd1, 32'd0, "unexpected result");
      else check({err, rd_valid ? rd_data : 8'h00}, exp_q.pop_front(), "result");
    end
  end

  task automatic run_op(input int op, input bit sel, input bit refuse);
    int k;
    int t0;
    int n0;
    logic [23:0] a;
    logic [31:0] w;
    logic [7:0] nrd;
    a = $urandom;
    a[16] = sel;
    w = $urandom;
    nrd = (op == 0 || op == 5) ? 8'h00 : 8'(1 + $urandom % 3);
    n0 = i_flash.n_cmd;
    if (refuse) exp_q.push_back(9'h100);
    else for (k = 0; k < nrd; k++) begin
      if (op == 6) exp_q.push_back(9'h040);
      else if (op == 7) exp_q.push_back({2'b00, !(sel && die1_hold), 6'h00});
      else exp_q.push_back({1'b0, codes[op] ^ k[7:0]});
    end
    k = 0;
    while (req_ready !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= nib_op_t'(op);
    req_addr <= a;
    req_wdata <= w;
    req_nread <= nrd;
    @(posedge mclk);
    req_valid <= 1'b0;
    t0 = cyc;
    k = 0;
    while (done !== 1'b1 && err !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    check(k < 3000, 1'b1, "sequence ended");
    check(err, refuse, "refusal");
    if (refuse) begin
      check(i_flash.n_cmd, n0, "bus idle on refusal");
      return;
    end
    check(i_flash.cmd1, codes[op], "command byte");
    check(i_flash.n_addr, naddr[op], "address count");
    for (k = 0; k < naddr[op]; k++) check(i_flash.abuf[k], a[8*k+:8], "address byte");
    check(i_flash.n_din, (op == 5) ? 4 : 0, "data count");
    if (op == 5) for (k = 0; k < 4; k++) check(i_flash.dbuf[k], w[8*k+:8], "feature byte");
    if (op == 8) check(i_flash.cmd2, CMD_RAND_CONF, "confirm");
    if (op == 0) begin
      check(cyc - t0 < BUSY, rb_monitor && !die1_hold, "reset wait");
      check(nand_ready, !die1_hold, "ready after reset");
    end
  endtask

  initial begin
    int k;
    int t0;
    int n0;
    seed = $urandom(32'h8b4e);
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    k = 0;
    while (init_done !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    check(init_done, 1'b1, "init");
    check(i_flash.first_cmd, CMD_RESET, "first command");
    check(i_flash.first_t >= 600, 1'b1, "reset after line high");
    for (k = 0; k < 9; k++) run_op(k, k[0], 1'b0);
    @(posedge mclk);
    die1_hold <= 1'b1;
    // The host only sees the line low after its synchroniser has settled
    repeat (6) @(negedge mclk);
    check(nand_ready, 1'b0, "line busy seen");
    run_op(1, 1'b0, 1'b1);
    run_op(8, 1'b0, 1'b1);
    run_op(7, 1'b1, 1'b0);
    run_op(7, 1'b0, 1'b0);
    run_op(6, 1'b0, 1'b0);
    run_op(0, 1'b0, 1'b0);
    @(posedge mclk);
    die1_hold <= 1'b0;
    rb_monitor <= 1'b0;
    run_op(0, 1'b0, 1'b0);
    run_op(4, 1'b0, 1'b0);
    // Second power-up without watching the line: blind wait, then reset again
    @(posedge mclk);
    rst_n <= 1'b0;
    n0 = i_flash.n_rst;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t0 = cyc;
    k = 0;
    while (init_done !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    check(init_done, 1'b1, "init blind");
    check(cyc - t0 >= 40 + BUSY, 1'b1, "blind power-up wait");
    check(i_flash.n_rst, n0 + 1, "reset reissued");
    check(exp_q.size(), 0, "all results seen");
    wrap_up();
  end
endmodule
